/* File: logic/cht_pkg.sv */
// package: register map, field positions and reset values of the card host interface
package cht_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE_CONFIG = 8'h04;
  localparam logic [7:0] OFS_DATA_TIMEOUT = 8'h08;
  localparam logic [7:0] OFS_CARD_SLOT_WIDTH = 8'h0c;
  localparam logic [7:0] OFS_COMMAND_ARGUMENT = 8'h10;
  localparam logic [7:0] OFS_COMMAND_ISSUE = 8'h14;
  localparam logic [7:0] OFS_RESPONSE_WORD0 = 8'h20;
  localparam logic [7:0] OFS_RESPONSE_WORD1 = 8'h24;
  localparam logic [7:0] OFS_RESPONSE_WORD2 = 8'h28;
  localparam logic [7:0] OFS_RESPONSE_WORD3 = 8'h2c;
  localparam logic [7:0] OFS_RECEIVE_DATA = 8'h30;
  localparam logic [7:0] OFS_TRANSMIT_DATA = 8'h34;
  localparam logic [7:0] OFS_STATUS_FLAGS = 8'h40;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h44;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h48;
  localparam logic [7:0] OFS_IRQ_MASK_VIEW = 8'h4c;
  // control bits
  localparam int CTL_IFACE_ENABLE = 0;
  localparam int CTL_IFACE_DISABLE = 1;
  localparam int CTL_POWER_SAVE_ON = 2;
  localparam int CTL_POWER_SAVE_OFF = 3;
  localparam int CTL_SOFT_RESET = 7;
  // mode_config fields
  localparam int MODE_CARD_CLOCK_DIVIDER_LSB = 0;
  localparam int MODE_POWER_SAVE_DIVIDER_LSB = 8;
  localparam int MODE_PAD_SEL = 14;
  localparam int MODE_DMA_SEL = 15;
  localparam int MODE_BLOCK_LENGTH_LSB = 16;
  localparam int MODE_BLOCK_LENGTH_W = 14;
  localparam logic [31:0] MODE_WRITE_MASK = 32'h3fffc7ff;
  localparam logic [31:0] MODE_RESET = 32'h00000000;
  localparam logic [31:0] DTO_WRITE_MASK = 32'h0000007f;
  localparam logic [31:0] SLOT_WRITE_MASK = 32'h0000008f;
  localparam int SLOT_BUS_WIDTH = 7;
  // command_issue fields
  localparam int CMD_TRCMD_LSB = 16;
  localparam int CMD_TRDIR = 18;
  localparam int CMD_TRTYP_LSB = 19;
  localparam logic [1:0] TRCMD_START = 2'h1;
  localparam logic [1:0] TRCMD_STOP = 2'h2;
  localparam logic [1:0] TRTYP_SINGLE = 2'h0;
  localparam logic [1:0] TRTYP_MULTI = 2'h1;
  localparam logic [1:0] TRTYP_STREAM = 2'h2;
  // status_flags bit positions
  localparam int ST_CMD_READY = 0;
  localparam int ST_RX_READY = 1;
  localparam int ST_TX_READY = 2;
  localparam int ST_BLOCK_END = 3;
  localparam int ST_NOT_BUSY = 5;
  localparam int ST_RX_IDLE = 6;
  localparam int ST_TX_IDLE = 7;
  localparam int ST_TX_EMPTY = 14;
  localparam int ST_RX_EMPTY = 15;
  localparam int ST_OVERRUN = 30;
  localparam int ST_UNDERRUN = 31;
  localparam logic [31:0] STATUS_RESET = 32'h0000c0e5;
  localparam logic [7:0] PAD_LOW = 8'h00;
  localparam logic [7:0] PAD_HIGH = 8'hff;
endpackage

/* File: logic/cht_card_host_interface.sv */
// card host interface: apb register bank, card clock divider and data transfer engine
// Functional notes
// - with dma mode set, data registers are served by the dma channel only
// - unfilled write block bytes are padded with 0x00 or 0xff by pad select
// - transfer completion shows in a status flag and raises the interrupt if enabled
// - single block, multiple block and stream transfers, read and write
// - in dma mode underrun and overrun flags clear when the transfer completes
// - card_slot_width selects the active slot and the data bus width
// - enable bit enables unless disable is also written; disable disables
// - power save on enters power save unless power save off written too
// - in power save, while no transfer is busy, the card clock is divided further by two to the divider
// - card clock is master clock over twice the divider plus one
// - soft reset bit performs a full reset of the interface logic
// - response words read by repeated reads at one address or consecutive ones
// - bus width bit clear uses one data line, set uses four
// - one line mode drives data line zero only, others stay free
// - interface stays disabled after reset until software enables it
module cht_card_host_interface (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic cardClk,
  output logic [3:0] slotSel,
  input wire logic [3:0] dataIn,
  output logic [3:0] dataOut,
  output logic [3:0] dataOeN,
  output logic dmaRxReq,
  output logic dmaTxReq,
  input wire logic dmaRxRead,
  input wire logic dmaTxWrite,
  input wire logic [31:0] dmaTxData,
  output logic [31:0] dmaRxData,
  input wire logic rspWrite,
  input wire logic [1:0] rspIndex,
  input wire logic [31:0] rspData
);
  logic [31:0] modeCfg;
  logic [31:0] dataTimeout;
  logic [31:0] slotWidth;
  logic [31:0] cmdArg;
  logic [31:0] irqMask;
  logic ifaceEnabled;
  logic powerSave;
  logic busy;
  logic dirRead;
  logic [1:0] xferType;
  logic stopReq;
  logic [31:0] shiftReg;
  logic [4:0] bitCnt;
  logic [13:0] byteCnt;
  logic [15:0] divCnt;
  logic [31:0] txData;
  logic txFull;
  logic [31:0] rxData;
  logic rxFull;
  logic underrun;
  logic overrun;
  logic blockEndFlag;
  logic [31:0] rspMem [4];
  logic [1:0] rspPtr;
  logic [31:0] statusWord;
  logic [31:0] readMux;
  logic [7:0] addr;
  logic addrMapped;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic ctrlWrite;
  logic softReset;
  logic startCmd;
  logic stopCmd;
  logic rspRead;
  logic dmaMode;
  logic wide;
  logic [7:0] padByte;
  logic [13:0] blockLen;
  logic psActive;
  logic [15:0] halfPeriod;
  logic clkToggle;
  logic dataEvent;
  logic [4:0] step;
  logic [4:0] next_bitCnt;
  logic byteBoundary;
  logic wordBoundary;
  logic loadWord;
  logic [31:0] txWord;
  logic [31:0] curWord;
  logic [31:0] rxShift;
  logic streamStop;
  logic blockLast;
  logic finishEvt;
  logic moveEvt;
  logic rxWordDone;
  logic txTaken;
  logic underrunEvt;
  logic overrunEvt;
  logic txLoad;
  logic [31:0] txLoadData;
  logic rxPop;
  logic statusRead;

  // apb decode; the slave never inserts wait states
  assign addr = {paddr[7:2], 2'b00};
  assign pready = 1'b1;
  assign apbAccess = psel & penable;
  assign apbWrite = apbAccess & pwrite;
  assign apbRead = apbAccess & ~pwrite;
  assign pslverr = apbAccess & ~addrMapped;
  assign ctrlWrite = apbWrite & (addr == cht_pkg::OFS_CONTROL);
  assign softReset = ctrlWrite & pwdata[cht_pkg::CTL_SOFT_RESET];
  assign statusRead = apbRead & (addr == cht_pkg::OFS_STATUS_FLAGS);
  assign rspRead = apbRead & (addr[7:4] == 4'h2);

  always_comb begin
    unique case (addr)
      cht_pkg::OFS_CONTROL, cht_pkg::OFS_MODE_CONFIG, cht_pkg::OFS_DATA_TIMEOUT,
      cht_pkg::OFS_CARD_SLOT_WIDTH, cht_pkg::OFS_COMMAND_ARGUMENT,
      cht_pkg::OFS_COMMAND_ISSUE, cht_pkg::OFS_RESPONSE_WORD0, cht_pkg::OFS_RESPONSE_WORD1,
      cht_pkg::OFS_RESPONSE_WORD2, cht_pkg::OFS_RESPONSE_WORD3, cht_pkg::OFS_RECEIVE_DATA,
      cht_pkg::OFS_TRANSMIT_DATA, cht_pkg::OFS_STATUS_FLAGS, cht_pkg::OFS_IRQ_ENABLE_SET,
      cht_pkg::OFS_IRQ_ENABLE_CLEAR, cht_pkg::OFS_IRQ_MASK_VIEW: addrMapped = 1'b1;
      default: addrMapped = 1'b0;
    endcase
  end

  // mode fields
  assign dmaMode = modeCfg[cht_pkg::MODE_DMA_SEL];
  assign padByte = modeCfg[cht_pkg::MODE_PAD_SEL] ? cht_pkg::PAD_HIGH : cht_pkg::PAD_LOW;
  assign blockLen = modeCfg[cht_pkg::MODE_BLOCK_LENGTH_LSB +: cht_pkg::MODE_BLOCK_LENGTH_W];
  assign wide = slotWidth[cht_pkg::SLOT_BUS_WIDTH];
  assign slotSel = slotWidth[3:0];

  // write-only and read-only registers read as zero where nothing is stored
  always_comb begin
    statusWord = 32'h0;
    statusWord[cht_pkg::ST_CMD_READY] = 1'b1;
    statusWord[cht_pkg::ST_RX_READY] = rxFull;
    statusWord[cht_pkg::ST_TX_READY] = ~txFull;
    statusWord[cht_pkg::ST_BLOCK_END] = blockEndFlag;
    statusWord[cht_pkg::ST_NOT_BUSY] = ~busy;
    statusWord[cht_pkg::ST_RX_IDLE] = ~(busy & dirRead);
    statusWord[cht_pkg::ST_TX_IDLE] = ~(busy & ~dirRead);
    statusWord[cht_pkg::ST_TX_EMPTY] = ~txFull;
    statusWord[cht_pkg::ST_RX_EMPTY] = ~rxFull;
    statusWord[cht_pkg::ST_OVERRUN] = overrun;
    statusWord[cht_pkg::ST_UNDERRUN] = underrun;
    unique case (addr)
      cht_pkg::OFS_MODE_CONFIG: readMux = modeCfg;
      cht_pkg::OFS_DATA_TIMEOUT: readMux = dataTimeout;
      cht_pkg::OFS_CARD_SLOT_WIDTH: readMux = slotWidth;
      cht_pkg::OFS_COMMAND_ARGUMENT: readMux = cmdArg;
      cht_pkg::OFS_RESPONSE_WORD0, cht_pkg::OFS_RESPONSE_WORD1, cht_pkg::OFS_RESPONSE_WORD2,
      cht_pkg::OFS_RESPONSE_WORD3: readMux = rspMem[rspPtr];
      cht_pkg::OFS_RECEIVE_DATA: readMux = rxData;
      cht_pkg::OFS_STATUS_FLAGS: readMux = statusWord;
      cht_pkg::OFS_IRQ_MASK_VIEW: readMux = irqMask;
      default: readMux = 32'h0;
    endcase
  end

  // read data is captured in the setup cycle so it stands through the access cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= readMux;
    end
  end

  assign irq = |(statusWord & irqMask);

  // enable and power save state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ifaceEnabled <= 1'b0;
      powerSave <= 1'b0;
    end else if (softReset) begin
      ifaceEnabled <= 1'b0;
      powerSave <= 1'b0;
    end else if (ctrlWrite) begin
      if (pwdata[cht_pkg::CTL_IFACE_DISABLE]) begin
        ifaceEnabled <= 1'b0;
      end else if (pwdata[cht_pkg::CTL_IFACE_ENABLE]) begin
        ifaceEnabled <= 1'b1;
      end
      if (pwdata[cht_pkg::CTL_POWER_SAVE_OFF]) begin
        powerSave <= 1'b0;
      end else if (pwdata[cht_pkg::CTL_POWER_SAVE_ON]) begin
        powerSave <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      modeCfg <= cht_pkg::MODE_RESET;
      dataTimeout <= 32'h0;
      slotWidth <= 32'h0;
      cmdArg <= 32'h0;
      irqMask <= 32'h0;
    end else if (softReset) begin
      modeCfg <= cht_pkg::MODE_RESET;
      dataTimeout <= 32'h0;
      slotWidth <= 32'h0;
      cmdArg <= 32'h0;
      irqMask <= 32'h0;
    end else if (apbWrite) begin
      unique case (addr)
        cht_pkg::OFS_MODE_CONFIG: modeCfg <= pwdata & cht_pkg::MODE_WRITE_MASK;
        cht_pkg::OFS_DATA_TIMEOUT: dataTimeout <= pwdata & cht_pkg::DTO_WRITE_MASK;
        cht_pkg::OFS_CARD_SLOT_WIDTH: slotWidth <= pwdata & cht_pkg::SLOT_WRITE_MASK;
        cht_pkg::OFS_COMMAND_ARGUMENT: cmdArg <= pwdata;
        cht_pkg::OFS_IRQ_ENABLE_SET: irqMask <= irqMask | pwdata;
        cht_pkg::OFS_IRQ_ENABLE_CLEAR: irqMask <= irqMask & ~pwdata;
        default: irqMask <= irqMask;
      endcase
    end
  end

  // response words: any response address returns the next word in turn
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rspPtr <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        rspMem[i] <= 32'h0;
      end
    end else if (softReset) begin
      rspPtr <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        rspMem[i] <= 32'h0;
      end
    end else begin
      if (rspWrite) begin
        rspMem[rspIndex] <= rspData;
      end
      if (rspWrite & (rspIndex == 2'h0)) begin
        rspPtr <= 2'h0;
      end else if (rspRead) begin
        rspPtr <= rspPtr + 2'h1;
      end
    end
  end

  // card clock: power save slows it only while no data moves
  assign psActive = powerSave & ~busy;
  assign halfPeriod = ({8'h00, modeCfg[cht_pkg::MODE_CARD_CLOCK_DIVIDER_LSB +: 8]} + 16'h0001)
    << (psActive ? modeCfg[cht_pkg::MODE_POWER_SAVE_DIVIDER_LSB +: 3] : 3'h0);
  assign clkToggle = ifaceEnabled & (divCnt >= halfPeriod - 16'h0001);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      divCnt <= 16'h0;
      cardClk <= 1'b0;
    end else if (softReset | ~ifaceEnabled) begin
      divCnt <= 16'h0;
      cardClk <= 1'b0;
    end else if (clkToggle) begin
      divCnt <= 16'h0;
      cardClk <= ~cardClk;
    end else begin
      divCnt <= divCnt + 16'h0001;
    end
  end

  // reads sample on the rising card edge, writes change on the falling one
  assign dataEvent = busy & clkToggle & (dirRead ? ~cardClk : cardClk);
  assign step = wide ? 5'h4 : 5'h1;
  assign next_bitCnt = bitCnt + step;
  assign byteBoundary = next_bitCnt[2:0] == 3'h0;
  assign wordBoundary = next_bitCnt == 5'h0;
  assign loadWord = ~dirRead & (bitCnt == 5'h0);
  assign txWord = (stopReq | ~txFull) ? {4{padByte}} : txData;
  assign curWord = loadWord ? txWord : shiftReg;
  assign rxShift = wide ? {shiftReg[27:0], dataIn} : {shiftReg[30:0], dataIn[0]};
  assign streamStop = (xferType == cht_pkg::TRTYP_STREAM) & stopReq & (bitCnt == 5'h0);
  assign blockLast = (xferType != cht_pkg::TRTYP_STREAM) & byteBoundary
    & ((byteCnt + 14'h0001) == blockLen);
  assign moveEvt = dataEvent & ~streamStop;
  assign finishEvt = dataEvent & (streamStop
    | (blockLast & ((xferType == cht_pkg::TRTYP_SINGLE) | stopReq)));

  // transfer engine
  assign startCmd = apbWrite & (addr == cht_pkg::OFS_COMMAND_ISSUE) & ~busy & ifaceEnabled
    & (pwdata[cht_pkg::CMD_TRCMD_LSB +: 2] == cht_pkg::TRCMD_START);
  assign stopCmd = apbWrite & (addr == cht_pkg::OFS_COMMAND_ISSUE)
    & (pwdata[cht_pkg::CMD_TRCMD_LSB +: 2] == cht_pkg::TRCMD_STOP);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      dirRead <= 1'b0;
      xferType <= cht_pkg::TRTYP_SINGLE;
      stopReq <= 1'b0;
      shiftReg <= 32'h0;
      bitCnt <= 5'h0;
      byteCnt <= 14'h0;
    end else if (softReset) begin
      busy <= 1'b0;
      dirRead <= 1'b0;
      xferType <= cht_pkg::TRTYP_SINGLE;
      stopReq <= 1'b0;
      shiftReg <= 32'h0;
      bitCnt <= 5'h0;
      byteCnt <= 14'h0;
    end else if (startCmd) begin
      busy <= 1'b1;
      dirRead <= pwdata[cht_pkg::CMD_TRDIR];
      xferType <= pwdata[cht_pkg::CMD_TRTYP_LSB +: 2];
      stopReq <= 1'b0;
      bitCnt <= 5'h0;
      byteCnt <= 14'h0;
    end else if (busy) begin
      if (stopCmd) begin
        stopReq <= 1'b1;
      end
      if (finishEvt) begin
        busy <= 1'b0;
      end
      if (moveEvt) begin
        shiftReg <= dirRead ? rxShift : (curWord << step);
        bitCnt <= next_bitCnt;
        if (byteBoundary) begin
          byteCnt <= blockLast ? 14'h0 : byteCnt + 14'h0001;
        end
      end
    end
  end

  // write pins: one line in narrow mode leaves lines 1 to 3 undriven;
  // the last bit stands until the falling card edge after the card sampled it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dataOut <= 4'h0;
      dataOeN <= 4'hf;
    end else if (softReset | ~ifaceEnabled | (busy & dirRead)) begin
      dataOut <= 4'h0;
      dataOeN <= 4'hf;
    end else if (moveEvt) begin
      dataOut <= wide ? curWord[31:28] : {3'h0, curWord[31]};
      dataOeN <= wide ? 4'h0 : 4'he;
    end else if (~busy & clkToggle & cardClk) begin
      dataOut <= 4'h0;
      dataOeN <= 4'hf;
    end
  end

  // data registers and flags; processor and dma paths never both count
  assign txLoad = dmaMode ? dmaTxWrite
    : (apbWrite & (addr == cht_pkg::OFS_TRANSMIT_DATA));
  assign txLoadData = dmaMode ? dmaTxData : pwdata;
  assign rxPop = dmaMode ? dmaRxRead
    : (apbRead & (addr == cht_pkg::OFS_RECEIVE_DATA));
  assign rxWordDone = moveEvt & dirRead & wordBoundary;
  assign txTaken = moveEvt & loadWord & ~stopReq & txFull;
  assign underrunEvt = moveEvt & loadWord & ~stopReq & ~txFull;
  assign overrunEvt = rxWordDone & rxFull & ~rxPop;
  assign dmaRxReq = dmaMode & rxFull;
  assign dmaTxReq = dmaMode & busy & ~dirRead & ~txFull;
  assign dmaRxData = rxData;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txData <= 32'h0;
      txFull <= 1'b0;
      rxData <= 32'h0;
      rxFull <= 1'b0;
      underrun <= 1'b0;
      overrun <= 1'b0;
      blockEndFlag <= 1'b0;
    end else if (softReset) begin
      txData <= 32'h0;
      txFull <= 1'b0;
      rxData <= 32'h0;
      rxFull <= 1'b0;
      underrun <= 1'b0;
      overrun <= 1'b0;
      blockEndFlag <= 1'b0;
    end else begin
      if (txLoad) begin
        txData <= txLoadData;
        txFull <= 1'b1;
      end else if (txTaken) begin
        txFull <= 1'b0;
      end
      if (rxWordDone) begin
        rxData <= rxShift;
        rxFull <= 1'b1;
      end else if (rxPop) begin
        rxFull <= 1'b0;
      end
      // a new event outranks the clear in the same cycle
      if (underrunEvt) begin
        underrun <= 1'b1;
      end else if (statusRead | (finishEvt & dmaMode)) begin
        underrun <= 1'b0;
      end
      if (overrunEvt) begin
        overrun <= 1'b1;
      end else if (statusRead | (finishEvt & dmaMode)) begin
        overrun <= 1'b0;
      end
      if (moveEvt & blockLast) begin
        blockEndFlag <= 1'b1;
      end else if (statusRead) begin
        blockEndFlag <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_ctrl_bits(int b);
    ctrlWrite && pwdata[b];
  endsequence
  sequence s_pad_load;
    moveEvt && loadWord && (stopReq || !txFull);
  endsequence

  AST_DISABLE_WINS: assert property (s_ctrl_bits(1) |=> !ifaceEnabled)
    else $error("disable did not win over enable");
  AST_ENABLE: assert property (s_ctrl_bits(0) ##0 (!pwdata[1] && !pwdata[7])
    |=> ifaceEnabled ##1 (ifaceEnabled || $past(ctrlWrite)))
    else $error("enable write did not enable the interface");
  AST_POWER_SAVE: assert property (s_ctrl_bits(2) ##0 (!pwdata[3] && !pwdata[7])
    |=> powerSave)
    else $error("power save not entered");
  AST_SOFT_RESET: assert property (s_ctrl_bits(7)
    |=> (modeCfg == 32'h0) && !busy && !ifaceEnabled && !txFull && !cardClk)
    else $error("soft reset left state behind");
  AST_CLOCK_DIV: assert property ((ifaceEnabled && $past(ifaceEnabled) && $changed(cardClk)
    && $stable(halfPeriod) && $past(halfPeriod) == $past(halfPeriod, 2)
    && !$past(softReset))
    |-> $past(divCnt) == halfPeriod - 16'h0001)
    else $error("card clock half period wrong");
  AST_POWER_SAVE_DIV: assert property ((psActive && modeCfg[10:8] == 3'h2)
    |-> halfPeriod == ({8'h00, modeCfg[7:0]} + 16'h0001) * 16'h0004)
    else $error("power save division wrong");
  AST_PAD: assert property (s_pad_load |=> dataOut == ($past(wide)
    ? {4{$past(modeCfg[14])}} : {3'h0, $past(modeCfg[14])}))
    else $error("pad value not driven");
  AST_DMA_ONLY: assert property ((dmaMode && apbWrite && addr == 8'h34 && !dmaTxWrite
    && !txFull) |=> !txFull)
    else $error("processor write accepted in dma mode");
  AST_DONE_IRQ: assert property (($fell(busy) && !$past(softReset)
    && xferType != cht_pkg::TRTYP_STREAM && irqMask[cht_pkg::ST_BLOCK_END])
    |-> irq && statusWord[cht_pkg::ST_BLOCK_END])
    else $error("completion not reported");
  AST_DMA_FLAGS: assert property ((finishEvt && dmaMode && !underrunEvt && !overrunEvt
    && !softReset) |=> !underrun && !overrun)
    else $error("flags not cleared at dma completion");
  AST_NARROW: assert property ((!wide && $stable(wide)) |-> dataOeN[3:1] == 3'h7)
    else $error("upper data lines driven in one line mode");
  AST_RSP_STEP: assert property ((rspRead && !rspWrite && !softReset)
    |=> rspPtr == 2'($past(rspPtr) + 2'h1))
    else $error("response pointer did not advance");
endmodule // cht_card_host_interface

/* File: tb/cht_card_model.sv */
// card model: drives the card data lines toward the host
module cht_card_model (
  input wire logic cardClk,
  output logic [3:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // lines 2 and 3 toggle on each falling card edge; lines 0 and 1 keep their start level
  initial dataIn = 4'h5;
  always @(negedge cardClk) begin
    dataIn <= ~dataIn ^ 4'h3;
  end
endmodule // cht_card_model

/* File: tb/tb.sv */
// testbench: apb driven scoreboard checks of the card host interface
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, rspWrite = 0, dmaTxWrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rspData = 32'h0, seed = 32'h50f6e238, rv, mv, got;
  logic [31:0] prdata, dmaRxData, dmaTxData = 32'h0;
  logic pready, pslverr, irq, cardClk, dmaRxReq, dmaTxReq;
  logic [3:0] slotSel, dataIn, dataOut, dataOeN;
  logic [1:0] rspIndex = 2'h0;
  logic [32:0] expQ[$], mskQ[$], ex, mk;
  logic [31:0] resp[4];
  int failures = 0, checked = 0, cyc = 0, n;
  always #10 clk_sys = ~clk_sys;
  cht_card_host_interface dut_u (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .cardClk(cardClk), .slotSel(slotSel),
    .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .dmaRxReq(dmaRxReq),
    .dmaTxReq(dmaTxReq), .dmaRxRead(1'b0), .dmaTxWrite(dmaTxWrite), .dmaTxData(dmaTxData),
    .dmaRxData(dmaRxData), .rspWrite(rspWrite), .rspIndex(rspIndex), .rspData(rspData));
  cht_card_model card_u (.cardClk(cardClk), .dataIn(dataIn));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m = '1);
    expQ.push_back(e);
    mskQ.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // one card clock high phase, counted in system cycles
  task automatic halfp(output int k);
    k = 0;
    @(posedge cardClk);
    while (cardClk === 1'b1) begin
      @(posedge clk_sys);
      #1 k++;
    end
  endtask
  task automatic xfer(input logic pad, input logic useTd, input logic [31:0] w, input logic w4);
    apb(1'b1, cht_pkg::OFS_CARD_SLOT_WIDTH, {24'h0, w4, 7'h0});
    apb(1'b1, cht_pkg::OFS_MODE_CONFIG, 32'h00040007 | (32'(pad) << 14));
    // with useTd set, data goes in before the start so the first word cannot underrun
    if (useTd) apb(1'b1, cht_pkg::OFS_TRANSMIT_DATA, w);
    apb(1'b1, cht_pkg::OFS_COMMAND_ISSUE, 32'h00010000);
    wait (dataOeN === (w4 ? 4'h0 : 4'he));
    for (int i = 0; i < (w4 ? 8 : 32); i++) begin
      @(posedge cardClk);
      got = w4 ? {got[27:0], dataOut} : {got[30:0], dataOut[0]};
    end
    `CHK("wire word", w, got)
    repeat (40) @(posedge clk_sys);
    `CHK("lines idle", 4'hf, dataOeN)
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      tally_and_finish();
    end
    if (psel && penable && !pwrite && pready) begin
      ex = expQ.pop_front();
      mk = mskQ.pop_front();
      `CHK("read", ex, {pslverr, prdata} & mk)
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(cht_pkg::OFS_MODE_CONFIG, 33'h0);
    rd(cht_pkg::OFS_DATA_TIMEOUT, 33'h0);
    rd(cht_pkg::OFS_COMMAND_ARGUMENT, 33'h0);
    rd(cht_pkg::OFS_STATUS_FLAGS, {1'b0, cht_pkg::STATUS_RESET});
    rd(cht_pkg::OFS_IRQ_MASK_VIEW, 33'h0);
    rd(8'h18, 33'h100000000);
    `CHK("clock off", 1'b0, cardClk)
    apb(1'b1, cht_pkg::OFS_CONTROL, 32'h3);
    repeat (30) @(posedge clk_sys);
    `CHK("clock off", 1'b0, cardClk)
    rv = $random(seed);
    mv = 32'h00040200 | 32'(rv[2:0]);
    apb(1'b1, cht_pkg::OFS_MODE_CONFIG, mv);
    rd(cht_pkg::OFS_MODE_CONFIG, {1'b0, mv});
    apb(1'b1, cht_pkg::OFS_CONTROL, 32'h1);
    halfp(n);
    halfp(n);
    `CHK("half period", 32'(rv[2:0]) + 1, n)
    apb(1'b1, cht_pkg::OFS_CONTROL, 32'hc);
    halfp(n);
    halfp(n);
    `CHK("no save", 32'(rv[2:0]) + 1, n)
    apb(1'b1, cht_pkg::OFS_CONTROL, 32'h4);
    halfp(n);
    halfp(n);
    `CHK("save period", (32'(rv[2:0]) + 1) * 4, n)
    apb(1'b1, cht_pkg::OFS_CONTROL, 32'h8);
    rv = $random(seed);
    apb(1'b1, cht_pkg::OFS_CARD_SLOT_WIDTH, rv & 32'h0000000f);
    rd(cht_pkg::OFS_CARD_SLOT_WIDTH, {1'b0, rv & 32'h0000000f});
    `CHK("slot", rv[3:0], slotSel)
    for (int i = 0; i < 4; i++) begin
      resp[i] = $random(seed);
      rspWrite <= 1'b1;
      rspIndex <= 2'(i);
      rspData <= resp[i];
      @(posedge clk_sys);
    end
    rspWrite <= 1'b0;
    for (int i = 0; i < 4; i++) rd(8'h20 + 8'(4 * i), {1'b0, resp[i]});
    rspWrite <= 1'b1;
    rspIndex <= 2'h0;
    rspData <= resp[0];
    @(posedge clk_sys);
    rspWrite <= 1'b0;
    for (int i = 0; i < 2; i++) rd(8'h20, {1'b0, resp[i]});
    apb(1'b1, cht_pkg::OFS_IRQ_ENABLE_SET, 32'h8);
    xfer(1'b0, 1'b1, rv, 1'b0);
    `CHK("irq", 1'b1, irq)
    rd(cht_pkg::OFS_STATUS_FLAGS, 33'h8, 33'h8);
    xfer(1'b1, 1'b0, 32'hffffffff, 1'b0);
    rd(cht_pkg::OFS_STATUS_FLAGS, 33'h80000008, 33'h80000008);
    rv = $random(seed);
    xfer(1'b0, 1'b1, rv, 1'b1);
    apb(1'b1, cht_pkg::OFS_MODE_CONFIG, 32'h00048007);
    apb(1'b1, cht_pkg::OFS_COMMAND_ISSUE, 32'h00010000);
    wait (dataOeN !== 4'hf);
    `CHK("dma request", 1'b1, dmaTxReq)
    apb(1'b1, cht_pkg::OFS_TRANSMIT_DATA, rv);
    dmaTxWrite <= 1'b1;
    dmaTxData <= ~rv;
    @(posedge clk_sys);
    `CHK("dma request", 1'b1, dmaTxReq)
    dmaTxWrite <= 1'b0;
    @(posedge clk_sys);
    `CHK("dma request", 1'b0, dmaTxReq)
    wait (dataOeN === 4'hf);
    rd(cht_pkg::OFS_STATUS_FLAGS, 33'h8, 33'hc0000008);
    apb(1'b1, cht_pkg::OFS_CONTROL, 32'h80);
    rd(cht_pkg::OFS_MODE_CONFIG, 33'h0);
    `CHK("clock off", 1'b0, cardClk)
    repeat (3) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule // tb
